// *** common/pin_share_pkg.sv ***
// Constants for the shared disk-data and upper-address pin control.
// Assumes a single 250 MHz core clock.
package pin_share_pkg;

    // ------------------------------------------------------------
    // Clock and strobe timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int IDX_SETUP_NS = 30;
    localparam int STROBE_MIN_NS = 70;
    localparam int IDX_HOLD_NS = 20;
    localparam int IDX_SETUP_CYC = (IDX_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_MIN_CYC = (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int IDX_HOLD_CYC = (IDX_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // Pin widths and field positions
    // ------------------------------------------------------------
    localparam int DD_W = 16;
    localparam int LA_W = 7;
    localparam int IDX_W = 3;
    localparam int MADDR_LSB = 3;
    localparam int MADDR_W = 13;
    localparam int LA_SEC_CMD = 6;
    localparam int LA_SEC_CTL = 5;
    localparam int LA_PRI_CMD = 4;
    localparam int LA_PRI_CTL = 3;
    localparam int LA_IDX_LSB = 0;

    // ------------------------------------------------------------
    // Transceiver control codes and reset values
    // ------------------------------------------------------------
    localparam logic XCVR_EN_ON_N = 1'h0;
    localparam logic XCVR_EN_OFF_N = 1'h1;
    localparam logic XCVR_DIR_TX = 1'h1;
    localparam logic XCVR_DIR_RX = 1'h0;
    localparam logic [LA_W-1:0] LA_RESET = 7'h00;
    localparam logic [DD_W-1:0] DD_RESET = 16'h0000;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_ISA    = 6'b000010,
        ST_SETUP  = 6'b000100,
        ST_STROBE = 6'b001000,
        ST_HOLD   = 6'b010000,
        ST_MASTER = 6'b100000
    } seq_state_t;

endpackage

// *** common/sync_if.sv ***
// Carrier between the pin control top and its input synchroniser.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] synced;
    modport owner (output raw, input synced);
    modport stage (input raw, output synced);
endinterface

// *** rtl/input_sync.sv ***
// Two-flop synchroniser for a group of pin inputs.
// Assumes raw inputs are asynchronous to mclk_i.
`timescale 1ns/1ps
module input_sync #(
    parameter int W = 1
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    sync_if.stage link
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= link.raw;
            sync_q <= meta_q;
        end
    end

    assign link.synced = sync_q;
endmodule

// *** rtl/ide_isa_shared_pin_control.sv ***
// Shares disk data and upper unlatched address pins between IDE and ISA use.
// Assumes requests come from core logic on mclk_i; pins are asynchronous.
//
// Contract
// (RL1) Drive ready is an input from the drives
// (RL2) Provide active-low transceiver output enable
// (RL3) Direction high unless an ISA master owns bus
// (RL4) Master granted: direction low, latch its address
// (RL5) Only three enable/direction combinations used
// (RL6) Secondary selects on address lines 23, 22
// (RL7) Primary selects on address lines 21, 20
// (RL8) Board inverts the four selects externally
// (RL9) Register index on address lines 19 to 17
// (RL10) Selects and index stable before strobe
// (RL11) Selects and index stable whole transaction
// (RL12) Board buffer enable tied active
// (RL13) Otherwise drive lines as ISA address 23:17
// (RL14) Disk data drives connectors and system address
// (RL15) Switch line use only between transactions
`timescale 1ns/1ps
module ide_isa_shared_pin_control
    import pin_share_pkg::*;
#(
    parameter int SETUP_CYC = IDX_SETUP_CYC,
    parameter int STROBE_CYC = STROBE_MIN_CYC,
    parameter int HOLD_CYC = IDX_HOLD_CYC
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Core side
    input wire logic isa_master_grant_i,
    input wire logic isa_cycle_i,
    input wire logic [LA_W-1:0] isa_upper_addr_i,
    input wire logic [DD_W-1:0] isa_dd_word_i,
    input wire logic ide_req_i,
    input wire logic ide_secondary_i,
    input wire logic ide_ctl_block_i,
    input wire logic ide_write_i,
    input wire logic [IDX_W-1:0] ide_index_i,
    input wire logic [DD_W-1:0] ide_wdata_i,
    output logic ide_ack_o,
    output logic [DD_W-1:0] ide_rdata_o,
    output logic [MADDR_W-1:0] master_addr_o,
    output logic [LA_W-1:0] master_upper_addr_o,
    output logic drive_ready_o,
    output logic busy_o,
    // Pins
    input wire logic drive_ready_in_i,
    input wire logic [DD_W-1:0] disk_data_bus_i,
    output logic [DD_W-1:0] disk_data_bus_o,
    output logic [DD_W-1:0] disk_data_bus_oe_o,
    input wire logic [LA_W-1:0] early_upper_addr_i,
    output logic [LA_W-1:0] early_upper_addr_o,
    output logic [LA_W-1:0] early_upper_addr_oe_o,
    output logic sys_xcvr_out_en_n_o,
    output logic sys_xcvr_direction_o,
    output logic drive_io_read_n_o,
    output logic drive_io_write_n_o
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    sync_if #(.W(1)) rdy_sync ();
    sync_if #(.W(DD_W)) dd_sync ();
    sync_if #(.W(LA_W)) la_sync ();

    assign rdy_sync.raw = drive_ready_in_i; // see (RL1)
    assign dd_sync.raw = disk_data_bus_i;
    assign la_sync.raw = early_upper_addr_i;

    input_sync #(.W(1)) u_rdy_sync (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .link(rdy_sync)
    );
    input_sync #(.W(DD_W)) u_dd_sync (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .link(dd_sync)
    );
    input_sync #(.W(LA_W)) u_la_sync (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .link(la_sync)
    );

    wire logic ready_s = rdy_sync.synced[0];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    seq_state_t state_q;
    seq_state_t state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    wire logic cnt_done = (cnt_q == '0);
    wire logic strobe_end = cnt_done && ready_s;

    // Line use changes only from idle, never mid-cycle
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_done ? cnt_q : cnt_q - CNT_W'(1);
        case (state_q)
            ST_IDLE: begin // see (RL15)
                if (isa_master_grant_i) begin
                    state_d = ST_MASTER;
                end else if (isa_cycle_i) begin
                    state_d = ST_ISA;
                end else if (ide_req_i) begin
                    state_d = ST_SETUP;
                    cnt_d = CNT_W'(SETUP_CYC - 1);
                end
            end
            ST_ISA: begin
                if (!isa_cycle_i) begin
                    state_d = ST_IDLE;
                end
            end
            ST_SETUP: begin // see (RL10)
                if (cnt_done) begin
                    state_d = ST_STROBE;
                    cnt_d = CNT_W'(STROBE_CYC - 1);
                end
            end
            ST_STROBE: begin // see (RL1)
                if (strobe_end) begin
                    state_d = ST_HOLD;
                    cnt_d = CNT_W'(HOLD_CYC - 1);
                end
            end
            ST_HOLD: begin // see (RL11)
                if (cnt_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_MASTER: begin
                if (!isa_master_grant_i) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------
    // Captured IDE request
    // ------------------------------------------------------------
    logic sec_q;
    logic ctl_q;
    logic wr_q;
    logic [IDX_W-1:0] idx_q;
    logic [DD_W-1:0] wdata_q;

    wire logic ide_take = (state_q == ST_IDLE) && (state_d == ST_SETUP);
    wire logic cur_sec = ide_take ? ide_secondary_i : sec_q;
    wire logic cur_ctl = ide_take ? ide_ctl_block_i : ctl_q;
    wire logic [IDX_W-1:0] cur_idx = ide_take ? ide_index_i : idx_q;
    wire logic [DD_W-1:0] cur_wdata = ide_take ? ide_wdata_i : wdata_q;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            sec_q <= 1'h0;
            ctl_q <= 1'h0;
            wr_q <= 1'h0;
            idx_q <= '0;
            wdata_q <= DD_RESET;
        end else if (ide_take) begin
            sec_q <= ide_secondary_i;
            ctl_q <= ide_ctl_block_i;
            wr_q <= ide_write_i;
            idx_q <= ide_index_i;
            wdata_q <= ide_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // Next pin values
    // ------------------------------------------------------------
    wire logic in_ide = (state_d == ST_SETUP) || (state_d == ST_STROBE) || (state_d == ST_HOLD);
    wire logic in_master = (state_d == ST_MASTER);
    wire logic in_isa = (state_d == ST_ISA);
    wire logic strobe_d = (state_d == ST_STROBE);

    // Active-high selects; the board inverts them
    logic [LA_W-1:0] ide_lines;
    always_comb begin
        ide_lines = '0;
        ide_lines[LA_SEC_CMD] = cur_sec && !cur_ctl; // see (RL6) (RL8)
        ide_lines[LA_SEC_CTL] = cur_sec && cur_ctl; // see (RL6)
        ide_lines[LA_PRI_CMD] = !cur_sec && !cur_ctl; // see (RL7)
        ide_lines[LA_PRI_CTL] = !cur_sec && cur_ctl; // see (RL7)
        ide_lines[LA_IDX_LSB +: IDX_W] = cur_idx; // see (RL9) (RL10)
    end

    logic [LA_W-1:0] isa_la_q;
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            isa_la_q <= LA_RESET;
        end else if (in_isa) begin
            isa_la_q <= isa_upper_addr_i;
        end
    end

    wire logic [LA_W-1:0] la_d = in_ide ? ide_lines : (in_isa ? isa_upper_addr_i : isa_la_q);
    wire logic la_oe_d = !in_master; // see (RL13) (RL12)
    wire logic [DD_W-1:0] dd_d = in_ide ? cur_wdata : isa_dd_word_i; // see (RL14)
    wire logic dd_oe_d = (in_ide && (ide_take ? ide_write_i : wr_q)) || in_isa;
    // Enable/direction pairs: 0/1 ISA, 1/1 IDE, 0/0 master
    wire logic soe_n_d = in_ide ? XCVR_EN_OFF_N : XCVR_EN_ON_N; // see (RL2) (RL5)
    wire logic sys_xcvr_direction_d = in_master ? XCVR_DIR_RX : XCVR_DIR_TX; // see (RL3) (RL4)

    // ------------------------------------------------------------
    // Pin registers
    // ------------------------------------------------------------
    logic [LA_W-1:0] la_q;
    logic la_oe_q;
    logic [DD_W-1:0] dd_q;
    logic dd_oe_q;
    logic soe_n_q;
    logic sys_xcvr_direction_q;
    logic drive_io_read_n_n_q;
    logic drive_io_write_n_n_q;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            la_q <= LA_RESET;
            la_oe_q <= 1'h1;
            dd_q <= DD_RESET;
            dd_oe_q <= 1'h0;
            soe_n_q <= XCVR_EN_ON_N;
            sys_xcvr_direction_q <= XCVR_DIR_TX;
            drive_io_read_n_n_q <= 1'h1;
            drive_io_write_n_n_q <= 1'h1;
        end else begin
            la_q <= la_d;
            la_oe_q <= la_oe_d;
            dd_q <= dd_d;
            dd_oe_q <= dd_oe_d;
            soe_n_q <= soe_n_d;
            sys_xcvr_direction_q <= sys_xcvr_direction_d;
            drive_io_read_n_n_q <= !(strobe_d && !wr_q);
            drive_io_write_n_n_q <= !(strobe_d && wr_q);
        end
    end

    // ------------------------------------------------------------
    // Captures toward the core
    // ------------------------------------------------------------
    logic [DD_W-1:0] rdata_q;
    logic [MADDR_W-1:0] maddr_q;
    logic [LA_W-1:0] mla_q;
    logic ready_q;

    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rdata_q <= DD_RESET;
            maddr_q <= '0;
            mla_q <= LA_RESET;
            ready_q <= 1'h0;
        end else begin
            ready_q <= ready_s;
            if (state_q == ST_STROBE && strobe_end && !wr_q) begin
                rdata_q <= dd_sync.synced;
            end
            if (state_q == ST_MASTER) begin
                maddr_q <= dd_sync.synced[MADDR_LSB +: MADDR_W]; // see (RL4)
                mla_q <= la_sync.synced;
            end
        end
    end

    assign ide_ack_o = (state_q == ST_HOLD) && cnt_done;
    assign ide_rdata_o = rdata_q;
    assign master_addr_o = maddr_q;
    assign master_upper_addr_o = mla_q;
    assign drive_ready_o = ready_q;
    assign busy_o = (state_q != ST_IDLE);
    assign disk_data_bus_o = dd_q;
    assign disk_data_bus_oe_o = {DD_W{dd_oe_q}};
    assign early_upper_addr_o = la_q;
    assign early_upper_addr_oe_o = {LA_W{la_oe_q}};
    assign sys_xcvr_out_en_n_o = soe_n_q;
    assign sys_xcvr_direction_o = sys_xcvr_direction_q;
    assign drive_io_read_n_o = drive_io_read_n_n_q;
    assign drive_io_write_n_o = drive_io_write_n_n_q;

endmodule

// *** verif/pin_ctl_assertions.sv ***
// Concurrent checks on the shared pin control top-level ports.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/1ps
module pin_ctl_assertions
    import pin_share_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic isa_master_grant_i,
    input wire logic busy_o,
    input wire logic [DD_W-1:0] disk_data_bus_oe_o,
    input wire logic [LA_W-1:0] early_upper_addr_o,
    input wire logic [LA_W-1:0] early_upper_addr_oe_o,
    input wire logic sys_xcvr_out_en_n_o,
    input wire logic sys_xcvr_direction_o,
    input wire logic drive_io_read_n_o,
    input wire logic drive_io_write_n_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    logic strb;
    assign strb = !drive_io_read_n_o || !drive_io_write_n_o;

    a_xcvr_combos: assert property (!(sys_xcvr_out_en_n_o && !sys_xcvr_direction_o))
        else $error("illegal transceiver control pair");
    a_rx_needs_grant: assert property (!sys_xcvr_direction_o
        |-> $past(isa_master_grant_i))
        else $error("receive direction without grant");
    a_idle_transmit: assert property (!busy_o && !$past(busy_o)
        |-> sys_xcvr_direction_o)
        else $error("direction not transmit while idle");
    a_master_released: assert property (!sys_xcvr_direction_o |->
        disk_data_bus_oe_o == 16'h0000 && early_upper_addr_oe_o == 7'h00)
        else $error("pins driven while master owns bus");
    a_strobe_selects: assert property (strb |-> $onehot(early_upper_addr_o[6:3])
        && early_upper_addr_oe_o == 7'h7F && sys_xcvr_out_en_n_o)
        else $error("strobe without one select");
    a_sel_setup: assert property ($rose(strb) |->
        $stable(early_upper_addr_o) && $past(sys_xcvr_out_en_n_o))
        else $error("selects not set up before strobe");
    a_sel_stable: assert property (sys_xcvr_out_en_n_o && $past(sys_xcvr_out_en_n_o)
        |-> $stable(early_upper_addr_o))
        else $error("selects moved during access");
    a_one_strobe: assert property (!(!drive_io_read_n_o && !drive_io_write_n_o))
        else $error("both strobes active");
endmodule

bind ide_isa_shared_pin_control pin_ctl_assertions u_chk (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .isa_master_grant_i(isa_master_grant_i),
    .busy_o(busy_o),
    .disk_data_bus_oe_o(disk_data_bus_oe_o),
    .early_upper_addr_o(early_upper_addr_o),
    .early_upper_addr_oe_o(early_upper_addr_oe_o),
    .sys_xcvr_out_en_n_o(sys_xcvr_out_en_n_o),
    .sys_xcvr_direction_o(sys_xcvr_direction_o),
    .drive_io_read_n_o(drive_io_read_n_o),
    .drive_io_write_n_o(drive_io_write_n_o)
);

// *** verif/ide_drive_model.sv ***
// Drives and board buffers beyond the shared pins.
// Assumes selects arrive active high and are inverted on the board.
`timescale 1ns/1ps
module ide_drive_model
    import pin_share_pkg::*;
(
    input wire logic mclk_i,
    input wire logic read_n_i,
    input wire logic stall_i,
    input wire logic xcvr_oe_n_i,
    input wire logic xcvr_dir_i,
    input wire logic [LA_W-1:0] la_i,
    input wire logic [MADDR_W-1:0] mst_addr_i,
    output logic [DD_W-1:0] dd_o,
    output logic ready_o
);
    logic [3:0] cs_n;
    logic [DD_W-1:0] last_q = 16'h0000;
    assign cs_n = ~la_i[6:3];
    assign ready_o = !stall_i;
    // Released bus shows a changing pattern
    always_comb begin
        if (!xcvr_oe_n_i && !xcvr_dir_i) dd_o = {mst_addr_i, 3'h5};
        else if (!read_n_i && cs_n != 4'hF) dd_o = {4'hA, cs_n, 5'h00, la_i[2:0]};
        else dd_o = ~last_q;
    end
    always @(posedge mclk_i) last_q <= dd_o;
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench for the shared pin control.
// Assumes the drive model and checker files are compiled first.
`timescale 1ns/1ps
module tb_top
    import pin_share_pkg::*;
;
    logic mclk_i = 0, reset_n_i = 0, grant = 0, isa_cyc = 0, req = 0, sec = 0, ctl = 0;
    logic wr = 0, stall = 0, ack, rdy_pin, rdy, busy, soe_n, sys_xcvr_direction, rd_n, wr_n;
    logic [LA_W-1:0] isa_la = 7'h00, la_o, la_oe, la_mst = 7'h00, m_upper, la_pin;
    logic [DD_W-1:0] isa_dd = 16'h0000, wdata = 16'h0000, rdata, dd_o, dd_oe, dd_mdl, dd_pin;
    logic [IDX_W-1:0] idx = 3'h0;
    logic [MADDR_W-1:0] m_addr, mst_addr = 13'h0000;
    int err_count = 0, num_checks = 0;
    assign dd_pin = (dd_oe == 16'hFFFF) ? dd_o : dd_mdl;
    assign la_pin = (la_oe == 7'h7F) ? la_o : la_mst;
    initial forever #2 mclk_i = ~mclk_i;

    ide_isa_shared_pin_control #(.SETUP_CYC(2), .STROBE_CYC(4), .HOLD_CYC(2)) dut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .isa_master_grant_i(grant),
        .isa_cycle_i(isa_cyc), .isa_upper_addr_i(isa_la), .isa_dd_word_i(isa_dd),
        .ide_req_i(req), .ide_secondary_i(sec), .ide_ctl_block_i(ctl), .ide_write_i(wr),
        .ide_index_i(idx), .ide_wdata_i(wdata), .ide_ack_o(ack), .ide_rdata_o(rdata),
        .master_addr_o(m_addr), .master_upper_addr_o(m_upper), .drive_ready_o(rdy),
        .busy_o(busy), .drive_ready_in_i(rdy_pin), .disk_data_bus_i(dd_pin),
        .disk_data_bus_o(dd_o), .disk_data_bus_oe_o(dd_oe), .early_upper_addr_i(la_pin),
        .early_upper_addr_o(la_o), .early_upper_addr_oe_o(la_oe),
        .sys_xcvr_out_en_n_o(soe_n), .sys_xcvr_direction_o(sys_xcvr_direction),
        .drive_io_read_n_o(rd_n), .drive_io_write_n_o(wr_n));

    ide_drive_model mdl (.mclk_i(mclk_i), .read_n_i(rd_n), .stall_i(stall),
        .xcvr_oe_n_i(soe_n), .xcvr_dir_i(sys_xcvr_direction), .la_i(la_pin), .mst_addr_i(mst_addr),
        .dd_o(dd_mdl), .ready_o(rdy_pin));

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        if (err_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic t_reset();
        check("rst_la", {la_oe, 1'b0, la_o}, 16'h7F00);
        check("rst_dd_oe", dd_oe, 16'h0000);
        check("rst_xcvr", {soe_n, sys_xcvr_direction, rd_n, wr_n}, 16'h0007);
        check("rst_busy", busy, 1'b0);
        check("rst_rdy", rdy, 1'b0);
    endtask

    task automatic t_ide(input logic s, input logic c, input logic w, input logic st,
                         input logic [IDX_W-1:0] i);
        logic [LA_W-1:0] e;
        int n;
        e = (7'h01 << (s ? (c ? 5 : 6) : (c ? 3 : 4))) | {4'h0, i};
        stall = st;
        if (st) repeat (4) @(negedge mclk_i);
        if (st) check("drv_rdy_low", rdy, 1'b0);
        sec = s;
        ctl = c;
        wr = w;
        idx = i;
        wdata = {8'hC3, 5'h00, i};
        req = 1;
        n = 0;
        while (rd_n && wr_n && n < 50) begin
            @(negedge mclk_i);
            n++;
        end
        check("ide_sel", la_o, e);
        check("ide_busy", busy, 1'b1);
        check("ide_xcvr", {soe_n, sys_xcvr_direction}, 16'h0003);
        check("ide_strobe", {rd_n, wr_n}, w ? 16'h0002 : 16'h0001);
        if (w) check("ide_wdata", dd_pin, wdata);
        n = 0;
        while (!ack && n < 100) begin
            @(negedge mclk_i);
            n++;
            if (n == 12) stall = 0;
        end
        check("ide_ack", ack, 1'b1);
        check("drv_rdy", rdy, 1'b1);
        if (st) check("ide_wait", n > 12, 1'b1);
        if (!w) check("ide_rdata", rdata, {4'hA, ~e[6:3], 5'h00, i});
        req = 0;
        @(negedge mclk_i);
    endtask

    task automatic t_isa();
        isa_la = 7'h55;
        isa_dd = 16'h5AA5;
        isa_cyc = 1;
        @(negedge mclk_i);
        req = 1;
        repeat (3) @(negedge mclk_i);
        check("isa_la", {la_oe, 1'b0, la_o}, 16'h7F55);
        check("isa_dd", dd_pin, 16'h5AA5);
        check("isa_xcvr", {soe_n, sys_xcvr_direction, rd_n, wr_n}, 16'h0007);
        check("isa_busy", busy, 1'b1);
        req = 0;
        isa_cyc = 0;
        repeat (3) @(negedge mclk_i);
    endtask

    task automatic t_master();
        mst_addr = 13'h1ABC;
        la_mst = 7'h2B;
        grant = 1;
        @(negedge mclk_i);
        req = 1;
        repeat (8) @(negedge mclk_i);
        check("mst_xcvr", {soe_n, sys_xcvr_direction, rd_n, wr_n}, 16'h0003);
        check("mst_addr", m_addr, 13'h1ABC);
        check("mst_upper", m_upper, 7'h2B);
        req = 0;
        grant = 0;
        repeat (4) @(negedge mclk_i);
        check("mst_end", {soe_n, sys_xcvr_direction}, 16'h0001);
    endtask

    initial begin
        #20000;
        err_count++;
        conclude();
    end

    initial begin
        repeat (4) @(negedge mclk_i);
        t_reset();
        @(negedge mclk_i);
        reset_n_i = 1;
        repeat (2) @(negedge mclk_i);
        for (int k = 0; k < 8; k++) t_ide(k[2], k[1], k[0], 1'b0, 3'(k));
        t_ide(1'b0, 1'b0, 1'b0, 1'b1, 3'h7);
        t_isa();
        t_master();
        conclude();
    end
endmodule
